// ==== vdc_defines.vh ====
// Contract
// - lock field selects four decoding modes
// - protocol select only valid in processor mode
// - coring enable, threshold one to four lsb
// - gaussian select: 0 response two, 1 one
// - notch threshold codes give 32,24,16,8
// - notch picks adaptive or fixed filter
// - linestore one input primary or secondary
// - linestore two delay: full line or active
// - invert msb into bandsplit filter
// - genlock data input delayed one line
// - mid sync level for subcarrier mode
// - video standard field, others reserved
// - output limit field selects clip ranges
// - mixed sync field controls sync, superblacks
// - invert chroma output msb
// - force chroma zero above luma limit
// - burst passes or zeroed on chroma
// - decimate chroma to 0:2:2
// - d1 serial component output enable
// - aux data bytes or nibbles rate
`ifndef VDC_DEFINES_VH
`define VDC_DEFINES_VH

// ****************************************
// register indices (byte address is index times four)
// ****************************************
`define VDC_IDX_BURST_LOOP   8'h02
`define VDC_IDX_CHROMA_PROC  8'h03
`define VDC_IDX_BURST_THR    8'h04
`define VDC_IDX_PEDESTAL     8'h05
`define VDC_IDX_LUMA_PROC    8'h06
`define VDC_IDX_COMB_PROC    8'h07
`define VDC_IDX_MID_SYNC     8'h08
`define VDC_IDX_RATE_STD     8'h09
`define VDC_IDX_OUT_CTL1     8'h0A
`define VDC_IDX_OUT_CTL2     8'h0B
`define VDC_IDX_COMB_FILT1   8'h0C
`define VDC_IDX_FIRST        8'h02
`define VDC_IDX_LAST         8'h0C
`define VDC_NUM_REGS         11
`define VDC_ADDR_SHIFT       2

// ****************************************
// field positions
// ****************************************
`define VDC_LOCK_HI          5
`define VDC_LOCK_LO          4
`define VDC_PROTO_BIT        6
`define VDC_CHROMA_CORING_ENABLE_BIT         4
`define VDC_CHROMA_CORING_THRESHOLD_HI          3
`define VDC_CHROMA_CORING_THRESHOLD_LO          2
`define VDC_GAUSSIAN_RESPONSE_SELECT_BIT       0
`define VDC_ADAPTIVE_NOTCH_ENABLE_BIT         5
`define VDC_ANT_HI           3
`define VDC_ANT_LO           2
`define VDC_NOTCH_BIT        0
`define VDC_FIRST_LINESTORE_INPUT_SELECT_BIT        6
`define VDC_SECOND_LINESTORE_DELAY_SELECT_BIT       5
`define VDC_BANDSPLIT_MSB_INVERT_BIT       1
`define VDC_GENDLY_BIT       0
`define VDC_VIDEO_STANDARD_FIELD_HI          3
`define VDC_VIDEO_STANDARD_FIELD_LO          0
`define VDC_OUTPUT_LIMIT_SELECT_HI         6
`define VDC_OUTPUT_LIMIT_SELECT_LO         5
`define VDC_MIXED_SYNC_FIELD_HI          4
`define VDC_MIXED_SYNC_FIELD_LO          3
`define VDC_CHROMA_OUTPUT_MSB_INVERT_BIT       2
`define VDC_LUMA_COLOR_CORRECTION_BIT         1
`define VDC_BURST_OUTPUT_ENABLE_BIT        0
`define VDC_CHROMA_DECIMATION_ENABLE_BIT         6
`define VDC_SERIAL_COMPONENT_OUTPUT_ENABLE_BIT         5
`define VDC_AUX_DATA_RATE_SELECT_BIT        0

// ****************************************
// reserved-bit write masks, reset value
// ****************************************
`define VDC_MASK_LUMA_PROC   8'h3F
`define VDC_MASK_OUT_CTL2    8'hE3
`define VDC_MASK_ALL         8'hFF
`define VDC_REG_RESET        8'h00

// ****************************************
// codes
// ****************************************
`define VDC_LOCK_LINE        2'h0
`define VDC_LOCK_SUBC        2'h1
`define VDC_LOCK_VIP         2'h2
`define VDC_LOCK_D1          2'h3
`define VDC_STD_NTSC_M       4'h0
`define VDC_STD_NTSC_EIAJ    4'h1
`define VDC_STD_PAL_BGHI     4'h8
`define VDC_STD_PAL_M        4'h9
`define VDC_STD_PAL_N_ARG    4'hA
`define VDC_STD_PAL_N_JAM    4'hB
`define VDC_LIM_RGB_A        2'h0
`define VDC_LIM_YC_WIDE      2'h1
`define VDC_LIM_RGB_B        2'h2
`define VDC_LIM_YC_STUDIO    2'h3
`define VDC_Y_MIN_WIDE       10'h004
`define VDC_Y_MAX_WIDE       10'h3F8
`define VDC_Y_MIN_STUDIO     10'h040
`define VDC_Y_MAX_STUDIO     10'h3AC
`define VDC_C_MAX_WIDE       10'h1F8
`define VDC_C_MAX_STUDIO     10'h1C0

`endif

// ==== vdc_field_decode.v ====
`include "vdc_defines.vh"

// turns packed register fields into the one-hot and numeric levels the datapath uses
module vdc_field_decode (
    // raw fields
    input  wire [1:0] lock_field,
    input  wire       proto_raw,
    input  wire [1:0] coring_code,
    input  wire [1:0] notch_thr_code,
    input  wire       notch_on,
    input  wire       notch_adaptive,
    input  wire [3:0] std_code,
    input  wire [1:0] limit_code,
    input  wire [1:0] msync_code,
    // decoded levels
    output reg  [3:0] lock_mode_onehot,
    output wire       input_protocol_eff,
    output wire [2:0] coring_lsb,
    output reg  [5:0] notch_limit,
    output wire       use_adaptive_notch,
    output wire       use_fixed_notch,
    output reg        standard_reserved,
    output reg        limit_is_ycbcr,
    output reg  [9:0] y_min,
    output reg  [9:0] y_max,
    output reg  [9:0] c_max,
    output wire       sync_on_green,
    output wire       sync_on_all,
    output wire       super_blacks
);

    // ****************************************
    // lock mode and protocol
    // ****************************************
    always @* begin
        case (lock_field)
            `VDC_LOCK_LINE: lock_mode_onehot = 4'h1;
            `VDC_LOCK_SUBC: lock_mode_onehot = 4'h2;
            `VDC_LOCK_VIP:  lock_mode_onehot = 4'h4;
            default:        lock_mode_onehot = 4'h8;
        endcase
    end

    // other lock modes mask the bit so the input stage never sees a stale value
    assign input_protocol_eff = proto_raw & (lock_field == `VDC_LOCK_VIP);

    // ****************************************
    // chroma coring and notch
    // ****************************************
    assign coring_lsb = {1'b0, coring_code} + 3'h1;

    always @* begin
        case (notch_thr_code)
            2'h0:    notch_limit = 6'h20;
            2'h1:    notch_limit = 6'h18;
            2'h2:    notch_limit = 6'h10;
            default: notch_limit = 6'h08;
        endcase
    end

    // comb special function downstream may still override this pick
    assign use_adaptive_notch = notch_on & notch_adaptive;
    assign use_fixed_notch    = notch_on & ~notch_adaptive;

    // ****************************************
    // standard, limits, sync
    // ****************************************
    always @* begin
        case (std_code)
            `VDC_STD_NTSC_M, `VDC_STD_NTSC_EIAJ, `VDC_STD_PAL_BGHI,
            `VDC_STD_PAL_M, `VDC_STD_PAL_N_ARG, `VDC_STD_PAL_N_JAM:
                standard_reserved = 1'b0;
            default: standard_reserved = 1'b1;
        endcase
    end

    always @* begin
        case (limit_code)
            `VDC_LIM_YC_STUDIO: begin
                limit_is_ycbcr = 1'b1;
                y_min          = `VDC_Y_MIN_STUDIO;
                y_max          = `VDC_Y_MAX_STUDIO;
                c_max          = `VDC_C_MAX_STUDIO;
            end
            `VDC_LIM_YC_WIDE: begin
                limit_is_ycbcr = 1'b1;
                y_min          = `VDC_Y_MIN_WIDE;
                y_max          = `VDC_Y_MAX_WIDE;
                c_max          = `VDC_C_MAX_WIDE;
            end
            default: begin
                limit_is_ycbcr = 1'b0;
                y_min          = `VDC_Y_MIN_WIDE;
                y_max          = `VDC_Y_MAX_WIDE;
                c_max          = `VDC_C_MAX_WIDE;
            end
        endcase
    end

    assign super_blacks  = msync_code[1];
    assign sync_on_green = msync_code[1] & ~msync_code[0];
    assign sync_on_all   = msync_code[1] & msync_code[0];

endmodule // vdc_field_decode

// ==== vdc_control_regs.v ====
`include "vdc_defines.vh"

module vdc_control_regs (
    // apb
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output wire        pready,
    output reg  [31:0] prdata,
    output wire        pslverr,
    // lock and input
    output wire [1:0]  lock_mode,
    output wire [3:0]  lock_mode_onehot,
    output wire        input_protocol_select,
    // chroma processing
    output wire        chroma_coring_enable,
    output wire [1:0]  chroma_coring_threshold,
    output wire [2:0]  coring_lsb,
    output wire        gaussian_response_select,
    // luma notch
    output wire [1:0]  adaptive_notch_threshold,
    output wire [5:0]  notch_limit,
    output wire        adaptive_notch_enable,
    output wire        use_adaptive_notch,
    output wire        use_fixed_notch,
    // comb linestores
    output wire        first_linestore_input_select,
    output wire        second_linestore_delay_select,
    output wire        bandsplit_msb_invert,
    output wire        genlock_data_delay,
    // sync and standard
    output wire [7:0]  mid_sync_level_value,
    output wire [3:0]  video_standard_field,
    output wire        standard_reserved,
    // output processing
    output wire [1:0]  output_limit_select,
    output wire        limit_is_ycbcr,
    output wire [9:0]  y_min,
    output wire [9:0]  y_max,
    output wire [9:0]  c_max,
    output wire [1:0]  mixed_sync_field,
    output wire        sync_on_green,
    output wire        sync_on_all,
    output wire        super_blacks,
    output wire        chroma_output_msb_invert,
    output wire        luma_color_correction,
    output wire        burst_output_enable,
    output wire        chroma_decimation_enable,
    output wire        serial_component_output_enable,
    output wire        aux_data_rate_select,
    // whole registers for fields not decoded here
    output wire [7:0]  burst_loop_control,
    output wire [7:0]  chroma_processor_control,
    output wire [7:0]  burst_threshold,
    output wire [7:0]  pedestal_level,
    output wire [7:0]  luma_processor_control,
    output wire [7:0]  comb_processor_control,
    output wire [7:0]  clock_rate_and_standard,
    output wire [7:0]  output_control_first,
    output wire [7:0]  output_control_second,
    output wire [7:0]  comb_filter_control_first
);

    // ****************************************
    // address decode
    // ****************************************
    function hit;
        input [7:0] addr;
        begin
            hit = (addr[1:0] == 2'h0) &&
                  ((addr >> `VDC_ADDR_SHIFT) >= `VDC_IDX_FIRST) &&
                  ((addr >> `VDC_ADDR_SHIFT) <= `VDC_IDX_LAST);
        end
    endfunction

    // reserved bits of the luma and second output registers cannot hold a one
    function [7:0] wmask;
        input [5:0] idx;
        begin
            case ({2'h0, idx})
                `VDC_IDX_LUMA_PROC: wmask = `VDC_MASK_LUMA_PROC;
                `VDC_IDX_OUT_CTL2:  wmask = `VDC_MASK_OUT_CTL2;
                default:            wmask = `VDC_MASK_ALL;
            endcase
        end
    endfunction

    wire [5:0] idx     = paddr[7:2];
    wire       mapped  = hit(paddr);
    wire       access  = psel & penable;

    // zero wait states: every access completes in its first access cycle
    assign pready  = 1'b1;
    assign pslverr = access & ~mapped;

    // ****************************************
    // register storage
    // ****************************************
    reg [7:0] regs [0:`VDC_NUM_REGS-1];
    integer   i;

    wire [3:0] slot = idx[3:0] - 4'h2;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (i = 0; i < `VDC_NUM_REGS; i = i + 1) begin
                regs[i] <= `VDC_REG_RESET;
            end
        end else if (access && pwrite && mapped && pstrb[0]) begin
            regs[slot] <= pwdata[7:0] & wmask(idx);
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= hit(paddr) ? {24'h00_0000, regs[slot]} : 32'h0000_0000;
        end
    end

    assign burst_loop_control        = regs[0];
    assign chroma_processor_control  = regs[1];
    assign burst_threshold           = regs[2];
    assign pedestal_level            = regs[3];
    assign luma_processor_control    = regs[4];
    assign comb_processor_control    = regs[5];
    assign mid_sync_level_value      = regs[6];
    assign clock_rate_and_standard   = regs[7];
    assign output_control_first      = regs[8];
    assign output_control_second     = regs[9];
    assign comb_filter_control_first = regs[10];

    // ****************************************
    // field extraction
    // ****************************************
    assign lock_mode = burst_loop_control[`VDC_LOCK_HI:`VDC_LOCK_LO];
    assign chroma_coring_enable    = chroma_processor_control[`VDC_CHROMA_CORING_ENABLE_BIT];
    assign chroma_coring_threshold = chroma_processor_control[`VDC_CHROMA_CORING_THRESHOLD_HI:`VDC_CHROMA_CORING_THRESHOLD_LO];
    assign gaussian_response_select = chroma_processor_control[`VDC_GAUSSIAN_RESPONSE_SELECT_BIT];
    assign adaptive_notch_threshold = luma_processor_control[`VDC_ANT_HI:`VDC_ANT_LO];
    assign adaptive_notch_enable    = luma_processor_control[`VDC_ADAPTIVE_NOTCH_ENABLE_BIT];
    assign first_linestore_input_select  = comb_processor_control[`VDC_FIRST_LINESTORE_INPUT_SELECT_BIT];
    assign second_linestore_delay_select = comb_processor_control[`VDC_SECOND_LINESTORE_DELAY_SELECT_BIT];
    assign bandsplit_msb_invert     = comb_processor_control[`VDC_BANDSPLIT_MSB_INVERT_BIT];
    assign genlock_data_delay       = comb_processor_control[`VDC_GENDLY_BIT];
    assign video_standard_field     = clock_rate_and_standard[`VDC_VIDEO_STANDARD_FIELD_HI:`VDC_VIDEO_STANDARD_FIELD_LO];
    assign output_limit_select      = output_control_first[`VDC_OUTPUT_LIMIT_SELECT_HI:`VDC_OUTPUT_LIMIT_SELECT_LO];
    assign mixed_sync_field         = output_control_first[`VDC_MIXED_SYNC_FIELD_HI:`VDC_MIXED_SYNC_FIELD_LO];
    assign chroma_output_msb_invert = output_control_first[`VDC_CHROMA_OUTPUT_MSB_INVERT_BIT];
    assign luma_color_correction    = output_control_first[`VDC_LUMA_COLOR_CORRECTION_BIT];
    assign burst_output_enable      = output_control_first[`VDC_BURST_OUTPUT_ENABLE_BIT];
    assign chroma_decimation_enable = output_control_second[`VDC_CHROMA_DECIMATION_ENABLE_BIT];
    assign serial_component_output_enable = output_control_second[`VDC_SERIAL_COMPONENT_OUTPUT_ENABLE_BIT];
    assign aux_data_rate_select     = output_control_second[`VDC_AUX_DATA_RATE_SELECT_BIT];

    // ****************************************
    // decoded levels
    // ****************************************
    vdc_field_decode u_decode (
        .lock_field         (lock_mode),
        .proto_raw          (burst_loop_control[`VDC_PROTO_BIT]),
        .coring_code        (chroma_coring_threshold),
        .notch_thr_code     (adaptive_notch_threshold),
        .notch_on           (luma_processor_control[`VDC_NOTCH_BIT]),
        .notch_adaptive     (adaptive_notch_enable),
        .std_code           (video_standard_field),
        .limit_code         (output_limit_select),
        .msync_code         (mixed_sync_field),
        .lock_mode_onehot   (lock_mode_onehot),
        .input_protocol_eff (input_protocol_select),
        .coring_lsb         (coring_lsb),
        .notch_limit        (notch_limit),
        .use_adaptive_notch (use_adaptive_notch),
        .use_fixed_notch    (use_fixed_notch),
        .standard_reserved  (standard_reserved),
        .limit_is_ycbcr     (limit_is_ycbcr),
        .y_min              (y_min),
        .y_max              (y_max),
        .c_max              (c_max),
        .sync_on_green      (sync_on_green),
        .sync_on_all        (sync_on_all),
        .super_blacks       (super_blacks)
    );

endmodule // vdc_control_regs

// ==== vdc_control_regs_checker.sv ====
// ****************************************
// property checker on the register bank ports
// ****************************************
module vdc_regs_checker (
    // apb
    input wire logic        pclk, presetn, psel, penable, pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    // decoded fields
    input wire logic [1:0]  lock_mode, chroma_coring_threshold, adaptive_notch_threshold,
    input wire logic [1:0]  output_limit_select, mixed_sync_field,
    input wire logic [3:0]  lock_mode_onehot, video_standard_field,
    input wire logic [2:0]  coring_lsb,
    input wire logic [5:0]  notch_limit,
    input wire logic [9:0]  y_min, y_max, c_max,
    input wire logic [7:0]  burst_loop_control, luma_processor_control, output_control_second,
    input wire logic [7:0]  mid_sync_level_value,
    input wire logic        input_protocol_select, use_adaptive_notch, use_fixed_notch,
    input wire logic        standard_reserved, sync_on_green, super_blacks
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_lock;
        lock_mode == burst_loop_control[5:4] && lock_mode_onehot == (4'h1 << lock_mode);
    endproperty
    a_lock: assert property (p_lock) else $error("lock decode wrong");
    property p_proto;
        input_protocol_select == (burst_loop_control[6] && lock_mode == 2'h2);
    endproperty
    a_proto: assert property (p_proto) else $error("protocol select leak");
    property p_coring;
        coring_lsb == {1'b0, chroma_coring_threshold} + 3'h1;
    endproperty
    a_coring: assert property (p_coring) else $error("coring lsb wrong");
    property p_notch;
        adaptive_notch_threshold == luma_processor_control[3:2]
            && notch_limit == 6'h20 - {1'b0, adaptive_notch_threshold, 3'h0};
    endproperty
    a_notch: assert property (p_notch) else $error("notch limit wrong");
    property p_notch_sel;
        use_adaptive_notch == (luma_processor_control[0] && luma_processor_control[5])
            && use_fixed_notch == (luma_processor_control[0] && !luma_processor_control[5]);
    endproperty
    a_notch_sel: assert property (p_notch_sel) else $error("notch choice wrong");
    // written value must show as the mid-sync level one edge later
    property p_write;
        psel && penable && pwrite && pstrb[0] && paddr == 8'h20
            |=> mid_sync_level_value == $past(pwdata[7:0]);
    endproperty
    a_write: assert property (p_write) else $error("write not stored");
    property p_hold;
        !(psel && penable && pwrite) |=> $stable(mid_sync_level_value);
    endproperty
    a_hold: assert property (p_hold) else $error("level moved without write");
    property p_read;
        psel && !penable && !pwrite && paddr == 8'h20
            |=> prdata == {24'h000000, $past(mid_sync_level_value)};
    endproperty
    a_read: assert property (p_read) else $error("read data wrong");
    property p_std;
        standard_reserved == !(video_standard_field inside {4'h0, 4'h1, 4'h8, 4'h9, 4'hA, 4'hB});
    endproperty
    a_std: assert property (p_std) else $error("reserved standard flag wrong");
    property p_limit;
        (output_limit_select == 2'h3) ? (y_min == 10'h040 && y_max == 10'h3AC && c_max == 10'h1C0)
            : (y_min == 10'h004 && y_max == 10'h3F8 && c_max == 10'h1F8);
    endproperty
    a_limit: assert property (p_limit) else $error("clip limits wrong");
    property p_sync;
        sync_on_green == (mixed_sync_field == 2'h2) && super_blacks == mixed_sync_field[1];
    endproperty
    a_sync: assert property (p_sync) else $error("sync field decode wrong");
    property p_resv;
        luma_processor_control[7:6] == 2'h0 && output_control_second[4:2] == 3'h0;
    endproperty
    a_resv: assert property (p_resv) else $error("reserved bit stored");
endmodule // vdc_regs_checker

bind vdc_control_regs vdc_regs_checker u_chk (.*);

// ==== test_video_decoder_control_regs.sv ====
module test_video_decoder_control_regs;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk, presetn, psel, penable, pwrite, e, mapped;
    logic [7:0]  paddr, a;
    logic [31:0] pwdata, q, r, d;
    logic [3:0]  pstrb;
    logic [7:0]  m [2:12];
    int          fail_count, cmp_count, seed, i, v;
    wire [31:0] prdata;
    wire [9:0]  y_min, y_max, c_max;
    wire [7:0]  burst_loop_control, chroma_processor_control, burst_threshold, pedestal_level,
                luma_processor_control, comb_processor_control, clock_rate_and_standard,
                output_control_first, output_control_second, comb_filter_control_first,
                mid_sync_level_value;
    wire [5:0]  notch_limit;
    wire [3:0]  lock_mode_onehot, video_standard_field;
    wire [2:0]  coring_lsb;
    wire [1:0]  lock_mode, chroma_coring_threshold, adaptive_notch_threshold,
                output_limit_select, mixed_sync_field;
    wire        pready, pslverr, input_protocol_select, chroma_coring_enable,
                gaussian_response_select, adaptive_notch_enable, use_adaptive_notch,
                use_fixed_notch, first_linestore_input_select, second_linestore_delay_select,
                bandsplit_msb_invert, genlock_data_delay, standard_reserved, limit_is_ycbcr,
                sync_on_green, sync_on_all, super_blacks, chroma_output_msb_invert,
                luma_color_correction, burst_output_enable, chroma_decimation_enable,
                serial_component_output_enable, aux_data_rate_select;

    vdc_control_regs u_dut (.*);

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [7:0] msk(input int k);
        return (k == 6) ? 8'h3F : (k == 11) ? 8'hE3 : 8'hFF;
    endfunction

    function automatic logic [29:0] lim(input logic [1:0] c);
        return (c == 2'h3) ? {10'h040, 10'h3AC, 10'h1C0} : {10'h004, 10'h3F8, 10'h1F8};
    endfunction

    task automatic conclude;
        if (fail_count == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] g, input logic [31:0] x);
        cmp_count++;
        if (g !== x) begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, g, x);
        end
    endtask

    // request held until pready is seen high; no release so transfers may run back to back
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] dt,
                       input logic [3:0] s);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= dt;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            fail_count++;
            $display("[ERR] %0t no ready", $time);
            conclude();
        end
        q = prdata;
        e = pslverr;
    endtask

    task automatic idle;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic check_fields;
        cmp(lock_mode, m[2][5:4]);
        cmp(input_protocol_select, m[2][6] && m[2][5:4] == 2'h2);
        cmp({chroma_coring_enable, coring_lsb}, {m[3][4], 3'(m[3][3:2] + 1)});
        cmp(gaussian_response_select, m[3][0]);
        cmp(notch_limit, 32 - 8 * m[6][3:2]);
        cmp({use_adaptive_notch, use_fixed_notch}, {m[6][0] & m[6][5], m[6][0] & ~m[6][5]});
        cmp({first_linestore_input_select, second_linestore_delay_select},
            m[7][6:5]);
        cmp({bandsplit_msb_invert, genlock_data_delay}, m[7][1:0]);
        cmp(mid_sync_level_value, m[8]);
        cmp(standard_reserved, !(m[9][3:0] inside {0, 1, 8, 9, 10, 11}));
        cmp({y_min, y_max, c_max}, lim(m[10][6:5]));
        cmp({sync_on_green, sync_on_all, super_blacks},
            {m[10][4:3] == 2'h2, m[10][4:3] == 2'h3, m[10][4]});
        cmp({chroma_output_msb_invert, luma_color_correction, burst_output_enable},
            m[10][2:0]);
        cmp({chroma_decimation_enable, serial_component_output_enable, aux_data_rate_select},
            {m[11][6], m[11][5], m[11][0]});
        cmp({burst_loop_control, chroma_processor_control, burst_threshold, pedestal_level},
            {m[2], m[3], m[4], m[5]});
        cmp({luma_processor_control, comb_processor_control, clock_rate_and_standard,
             output_control_first}, {m[6], m[7], m[9], m[10]});
        cmp({output_control_second, comb_filter_control_first}, {m[11], m[12]});
        cmp({lock_mode_onehot, chroma_coring_threshold, adaptive_notch_threshold},
            {4'h1 << m[2][5:4], m[3][3:2], m[6][3:2]});
        cmp({adaptive_notch_enable, video_standard_field, limit_is_ycbcr,
             output_limit_select, mixed_sync_field},
            {m[6][5], m[9][3:0], m[10][5], m[10][6:5], m[10][4:3]});
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        seed = 32'h63A1;
        fail_count = 0;
        cmp_count = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'h0;
        foreach (m[k]) m[k] = 8'h00;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check_fields();
        for (i = 2; i <= 12; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0, 4'h0);
            cmp(q, 32'h0);
        end
        // every code of every field; software keeps reserved bits at zero
        for (v = 0; v < 256; v++) begin
            for (i = 2; i <= 12; i++) begin
                r = $random(seed);
                apb(1'b1, 8'(i * 4), {r[31:8], 8'(v) & msk(i)}, 4'hF);
                m[i] = 8'(v) & msk(i);
            end
            idle();
            check_fields();
        end
        for (v = 0; v < 600; v++) begin
            r = $random(seed);
            d = $random(seed);
            i = 2 + r[11:8] % 11;
            a = r[0] ? 8'(i * 4) : r[23:16];
            mapped = a[1:0] == 2'h0 && a >= 8'h08 && a <= 8'h30;
            if (mapped) d[7:0] = d[7:0] & msk(a >> 2);
            apb(r[1], a, d, r[7:4]);
            cmp(e, !mapped);
            if (!r[1]) cmp(q, mapped ? {24'h0, m[a >> 2]} : 32'h0);
            else if (mapped && r[4]) m[a >> 2] = d[7:0] & msk(a >> 2);
            if (r[2]) begin
                idle();
                check_fields();
            end
        end
        idle();
        check_fields();
        conclude();
    end
endmodule // test_video_decoder_control_regs
